// [src/ceie_top.sv]
// comparator edge interrupt select block: registers, pending flags, int output
`timescale 1ns/1ps
`default_nettype none
`include "ceie_defs.svh"

module ceie_top #(
  parameter int N_INPUTS   = `CEIE_N_INPUTS,
  parameter int GROUP_SIZE = `CEIE_GROUP_SIZE
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       spi_cs_n,
  input  wire logic                       spi_sclk,
  input  wire logic                       spi_mosi,
  output logic                            spi_miso,
  output logic                            spi_miso_oe_n,
  input  wire logic                       sample_valid,
  input  wire ceie_pkg::ceie_levels_t [23:0] cmp_levels,
  input  wire logic [1:0]                 group0_threshold_level,
  input  wire logic [1:0]                 group1_threshold_level,
  input  wire logic [1:0]                 group2_threshold_level,
  input  wire logic [1:0]                 group3_threshold_level,
  input  wire logic [1:0]                 group4_threshold_level,
  input  wire logic [1:0]                 group5_threshold_level,
  output logic [23:0]                     cmp_irq_pending,
  output logic                            int_n
);
  import ceie_pkg::*;

  localparam int N_GROUPS = `CEIE_N_GROUPS;
  localparam int HALF     = `CEIE_HIGH_FIRST;

  ceie_req_t                  req;
  logic [23:0]                rdata;
  logic [23:0]                edge_irq_select_low_inputs;
  logic [23:0]                edge_irq_select_high_inputs;
  logic [23:0]                edge_dir;
  logic [N_INPUTS-1:0]        level;
  logic [N_INPUTS-1:0]        edge_hit;
  logic [N_INPUTS-1:0]        edge_rise;
  logic [N_INPUTS-1:0][1:0]   cond;
  logic [N_GROUPS-1:0][1:0]   group_thr;

  // serial register port
  ceie_spi_port u_port (
    .clock         (clock),
    .rst_n         (rst_n),
    .spi_cs_n      (spi_cs_n),
    .spi_sclk      (spi_sclk),
    .spi_mosi      (spi_mosi),
    .spi_miso      (spi_miso),
    .spi_miso_oe_n (spi_miso_oe_n),
    .req           (req),
    .rdata         (rdata)
  );

  // threshold codes of the six input groups, group g serves inputs 4g..4g+3
  assign group_thr[0] = group0_threshold_level;
  assign group_thr[1] = group1_threshold_level;
  assign group_thr[2] = group2_threshold_level;
  assign group_thr[3] = group3_threshold_level;
  assign group_thr[4] = group4_threshold_level;
  assign group_thr[5] = group5_threshold_level;

  // field of input n: low register for n < 12, high register above
  function automatic logic [1:0] field_of(input logic [23:0] lo, input logic [23:0] hi,
                                          input int n);
    logic [1:0] f;
    f = 2'h0;
    if (n < HALF)
      f = lo[2*n +: 2];
    else
      f = hi[2*(n-HALF) +: 2];
    return f;
  endfunction : field_of

  // condition field of every input
  always_comb
  begin
    for (int n = 0; n < N_INPUTS; n++)
      cond[n] = field_of(edge_irq_select_low_inputs, edge_irq_select_high_inputs, n);
  end

  // crossing detection against the selected group level
  ceie_edge_bank #(
    .N_INPUTS   (N_INPUTS),
    .GROUP_SIZE (GROUP_SIZE),
    .N_GROUPS   (N_GROUPS)
  ) u_edges (
    .clock        (clock),
    .rst_n        (rst_n),
    .sample_valid (sample_valid),
    .cmp_levels   (cmp_levels),
    .group_thr    (group_thr),
    .cond         (cond),
    .level        (level),
    .edge_hit     (edge_hit),
    .edge_rise    (edge_rise)
  );

  // write decode; unmapped offsets are ignored
  wire        wr_low     = req.wr && req.addr == `CEIE_OFS_SEL_LOW;
  wire        wr_high    = req.wr && req.addr == `CEIE_OFS_SEL_HIGH;
  wire        wr_pending = req.wr && req.addr == `CEIE_OFS_PENDING;
  wire [23:0] clear_mask = wr_pending ? req.wdata : 24'h000000;

  // next register values
  wire [23:0] next_sel_low  = wr_low ? req.wdata : edge_irq_select_low_inputs;
  wire [23:0] next_sel_high = wr_high ? req.wdata : edge_irq_select_high_inputs;

  // a hit in the clearing cycle wins over the clear
  wire [23:0] next_pending  = (cmp_irq_pending & ~clear_mask) | edge_hit;
  wire [23:0] next_edge_dir = (edge_dir & ~edge_hit) | (edge_hit & edge_rise);
  wire        next_int_n    = ~|next_pending;

  // read decode; unmapped offsets read as zero
  assign rdata = (req.addr == `CEIE_OFS_SEL_LOW)  ? edge_irq_select_low_inputs :
                 (req.addr == `CEIE_OFS_SEL_HIGH) ? edge_irq_select_high_inputs :
                 (req.addr == `CEIE_OFS_PENDING)  ? cmp_irq_pending :
                 (req.addr == `CEIE_OFS_LEVEL)    ? level :
                 (req.addr == `CEIE_OFS_EDGE_DIR) ? edge_dir :
                 24'h000000;

  // select registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      edge_irq_select_low_inputs  <= `CEIE_RST_SEL;
      edge_irq_select_high_inputs <= `CEIE_RST_SEL;
    end
    else
    begin
      edge_irq_select_low_inputs  <= next_sel_low;
      edge_irq_select_high_inputs <= next_sel_high;
    end
  end

  // pending flags, last edge direction and interrupt pin
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmp_irq_pending <= `CEIE_RST_PENDING;
      edge_dir        <= 24'h000000;
      int_n           <= 1'b1;
    end
    else
    begin
      cmp_irq_pending <= next_pending;
      edge_dir        <= next_edge_dir;
      int_n           <= next_int_n;
    end
  end

endmodule : ceie_top
`default_nettype wire

// [src/ceie_defs.svh]
// constants for the comparator edge interrupt select block
// Contract
// - each input has a 2-bit condition field; code 0 blocks its comparator interrupts
// - code 1 raises an interrupt only on a rising crossing of the group threshold
// - code 2 raises an interrupt only on a falling crossing of the group threshold
// - code 3 raises an interrupt on both rising and falling crossings
// - inputs 0-3 use the group 0 threshold, inputs 4-7 the group 1 threshold
// - inputs 20-23 use the group 5 threshold, input 19 the group 4 threshold
// - the high-input select register sits at 23h and resets to zero
// - in the low register input n occupies bits 2n+1 down to 2n
// - in the high register input n occupies bits 2(n-12)+1 down to 2(n-12)
// - every select field reads back the last value written, zero after reset
// - the low-input select register sits at 22h and resets to zero
// - threshold codes 0..3 pick the 2V, 2.7V, 3V and 4V comparator levels
`ifndef CEIE_DEFS_SVH
`define CEIE_DEFS_SVH

// register offsets on the serial port
`define CEIE_OFS_SEL_LOW   6'h22
`define CEIE_OFS_SEL_HIGH  6'h23
`define CEIE_OFS_PENDING   6'h3A
`define CEIE_OFS_LEVEL     6'h3B
`define CEIE_OFS_EDGE_DIR  6'h3C

// reset values
`define CEIE_RST_SEL       24'h000000
`define CEIE_RST_PENDING   24'h000000

// field layout
`define CEIE_FIELD_W       2
`define CEIE_HIGH_FIRST    12
`define CEIE_GROUP_SIZE    4
`define CEIE_N_INPUTS      24
`define CEIE_N_GROUPS      6

// threshold levels behind codes 0..3, in millivolts
`define CEIE_THR_CODE0_MV  2000
`define CEIE_THR_CODE1_MV  2700
`define CEIE_THR_CODE2_MV  3000
`define CEIE_THR_CODE3_MV  4000

// serial frame: 1 direction bit, 6 address bits, 24 data bits, 1 pad bit
`define CEIE_SPI_FRAME_BITS 6'd32
`define CEIE_SPI_HEAD_BITS  6'd7
`define CEIE_SPI_DATA_BITS  24

`endif

// [src/ceie_pkg.sv]
// types shared by the comparator edge interrupt select block
package ceie_pkg;

  // condition codes of a select field
  typedef enum logic [1:0] {
    COND_NONE,
    COND_RISE,
    COND_FALL,
    COND_BOTH
  } ceie_cond_t;

  // one register access decoded from a serial frame
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [23:0] wdata;
  } ceie_req_t;

  // comparator outputs of one input at the four levels, bit k = level code k
  typedef logic [3:0] ceie_levels_t;

  // serial frame phases
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_HEAD,
    SPI_DATA
  } ceie_spi_state_t;

endpackage : ceie_pkg

// [src/ceie_spi_port.sv]
// serial register port: pin synchronisers, frame decode and read shifter
`timescale 1ns/1ps
`default_nettype none
`include "ceie_defs.svh"

module ceie_spi_port (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_sclk,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe_n,
  output ceie_pkg::ceie_req_t    req,
  input  wire logic [23:0]       rdata
);
  import ceie_pkg::*;

  logic            cs_s1, cs_s2, cs_s3;
  logic            sclk_s1, sclk_s2, sclk_s3;
  logic            mosi_s1, mosi_s2;
  logic [5:0]      bit_cnt;
  logic [31:0]     in_shift;
  logic [23:0]     out_shift;
  ceie_spi_state_t state;

  // pin synchronisers; the second stage is looked at, the third only to find sclk and select edges
  always_ff @(posedge clock)
  begin
    cs_s1   <= spi_cs_n;
    cs_s2   <= cs_s1;
    cs_s3   <= cs_s2;
    sclk_s1 <= spi_sclk;
    sclk_s2 <= sclk_s1;
    sclk_s3 <= sclk_s2;
    mosi_s1 <= spi_mosi;
    mosi_s2 <= mosi_s1;
  end

  // frame decode
  wire             frame_on   = ~cs_s2;
  wire             sclk_rise  = frame_on & sclk_s2 & ~sclk_s3;
  wire             sclk_fall  = frame_on & ~sclk_s2 & sclk_s3;
  wire             frame_end  = cs_s2 & ~cs_s3;
  wire             head_done  = sclk_rise & (bit_cnt == `CEIE_SPI_HEAD_BITS - 6'd1);
  wire             head_read  = head_done & ~in_shift[5];
  wire             full_write = frame_end & (bit_cnt == `CEIE_SPI_FRAME_BITS) & in_shift[31];
  wire             shift_out  = sclk_fall & (bit_cnt > `CEIE_SPI_HEAD_BITS);
  wire [5:0]       next_bit_cnt = !frame_on ? 6'h00 :
                                  (sclk_rise && bit_cnt != `CEIE_SPI_FRAME_BITS) ?
                                  bit_cnt + 6'h01 : bit_cnt;
  wire [31:0]      next_in_shift = sclk_rise ? {in_shift[30:0], mosi_s2} : in_shift;
  wire [23:0]      next_out_shift = req.rd ? rdata :
                                    shift_out ? {out_shift[22:0], 1'b0} : out_shift;
  ceie_spi_state_t next_state;
  ceie_req_t       next_req;

  // phase tracking
  always_comb
  begin
    next_state = state;
    unique case (state)
      SPI_IDLE: if (frame_on) next_state = SPI_HEAD;
      SPI_HEAD: if (!frame_on) next_state = SPI_IDLE;
                else if (head_done) next_state = SPI_DATA;
      SPI_DATA: if (!frame_on) next_state = SPI_IDLE;
    endcase
  end

  // access request, one cycle per frame
  always_comb
  begin
    next_req.rd    = head_read && state == SPI_HEAD;
    next_req.wr    = full_write;
    next_req.addr  = full_write ? in_shift[30:25] : {in_shift[4:0], mosi_s2};
    next_req.wdata = in_shift[24:1];
  end

  // registers of the port
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state     <= SPI_IDLE;
      bit_cnt   <= 6'h00;
      in_shift  <= 32'h00000000;
      out_shift <= 24'h000000;
      req       <= '0;
      spi_miso  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      in_shift  <= next_in_shift;
      out_shift <= next_out_shift;
      req       <= next_req;
      spi_miso  <= next_out_shift[23];
    end
  end

  assign spi_miso_oe_n = cs_s2; // driven only while selected

endmodule : ceie_spi_port
`default_nettype wire

// [src/ceie_edge_bank.sv]
// per-input threshold pick and crossing detection
`timescale 1ns/1ps
`default_nettype none
`include "ceie_defs.svh"

module ceie_edge_bank #(
  parameter int N_INPUTS   = 24,
  parameter int GROUP_SIZE = 4,
  parameter int N_GROUPS   = 6
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        sample_valid,
  input  wire logic [N_INPUTS-1:0][3:0]    cmp_levels,
  input  wire logic [N_GROUPS-1:0][1:0]    group_thr,
  input  wire logic [N_INPUTS-1:0][1:0]    cond,
  output logic      [N_INPUTS-1:0]         level,
  output logic      [N_INPUTS-1:0]         edge_hit,
  output logic      [N_INPUTS-1:0]         edge_rise
);
  import ceie_pkg::*;

  logic                primed;
  logic [N_INPUTS-1:0] cur;
  logic [N_INPUTS-1:0] rise_ok;
  logic [N_INPUTS-1:0] fall_ok;

  // group that an input shares its threshold with
  function automatic int group_of(input int n);
    return n / GROUP_SIZE;
  endfunction : group_of

  // comparator output at the level that a threshold code selects
  function automatic logic pick_level(input logic [3:0] lv, input logic [1:0] code);
    return lv[code];
  endfunction : pick_level

  // crossing qualification per input
  always_comb
  begin
    for (int i = 0; i < N_INPUTS; i++)
    begin
      cur[i]     = pick_level(cmp_levels[i], group_thr[group_of(i)]);
      rise_ok[i] = (cond[i] == COND_RISE || cond[i] == COND_BOTH) & cur[i] & ~level[i];
      fall_ok[i] = (cond[i] == COND_FALL || cond[i] == COND_BOTH) & ~cur[i] & level[i];
    end
  end

  // first sample after reset only primes the history
  wire                compare_now = sample_valid & primed;
  wire [N_INPUTS-1:0] next_hit    = compare_now ? (rise_ok | fall_ok) : '0;
  wire [N_INPUTS-1:0] next_level  = sample_valid ? cur : level;

  // sample history and one-cycle hit pulses
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      primed    <= 1'b0;
      level     <= '0;
      edge_hit  <= '0;
      edge_rise <= '0;
    end
    else
    begin
      primed    <= primed | sample_valid;
      level     <= next_level;
      edge_hit  <= next_hit;
      edge_rise <= compare_now ? rise_ok : '0;
    end
  end

endmodule : ceie_edge_bank
`default_nettype wire

// [verification/ceie_top_props.sv]
// port assertions for the comparator edge interrupt select block
`timescale 1ns/1ps
`default_nettype none
module ceie_top_props #(
  parameter int N_INPUTS   = 24,
  parameter int GROUP_SIZE = 4
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        spi_cs_n,
  input wire logic        spi_sclk,
  input wire logic        spi_miso,
  input wire logic        spi_miso_oe_n,
  input wire logic        sample_valid,
  input wire logic [23:0] cmp_irq_pending,
  input wire logic        int_n
);
  import ceie_pkg::*;
  logic [1:0] pins_q;    // sclk and select pins one edge ago
  logic [3:0] since_cs;  // edges since select was low
  logic [3:0] since_pin; // edges since sclk or select moved
  // saturating quiet-time counters
  always_ff @(posedge clock)
  begin
    pins_q <= {spi_sclk, spi_cs_n};
    if (!rst_n)
    begin
      since_cs  <= 4'hF;
      since_pin <= 4'hF;
    end
    else
    begin
      since_cs <= !spi_cs_n ? 4'h0 : since_cs + {3'h0, since_cs != 4'hF};
      since_pin <= pins_q != {spi_sclk, spi_cs_n} ? 4'h0 : since_pin + {3'h0, since_pin != 4'hF};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_cs_rise; $rose(spi_cs_n); endsequence
  sequence s_cs_fall; $fell(spi_cs_n); endsequence
  sequence s_new_pend; |(cmp_irq_pending & ~$past(cmp_irq_pending)); endsequence
  sequence s_drop_pend; |($past(cmp_irq_pending) & ~cmp_irq_pending); endsequence
  chk_reset_outputs: assert property (disable iff (1'b0)
    !rst_n |=> int_n && !spi_miso && cmp_irq_pending == 24'h0) else $error("reset not seen");
  chk_int_follows: assert property (int_n == ~|cmp_irq_pending)
    else $error("int_n disagrees with pending");
  chk_set_cause: assert property (s_new_pend |-> $past(sample_valid, 2))
    else $error("pending set without a sample");
  chk_clear_cause: assert property (s_drop_pend |-> since_cs < 4'd12)
    else $error("pending cleared without a host write");
  chk_oe_release: assert property (s_cs_rise |-> !spi_miso_oe_n [*2] ##1 spi_miso_oe_n)
    else $error("miso enable late on release");
  chk_oe_drive: assert property (s_cs_fall |-> spi_miso_oe_n [*2] ##1 !spi_miso_oe_n)
    else $error("miso enable late on select");
  chk_miso_quiet: assert property ($changed(spi_miso) |-> since_pin < 4'd8)
    else $error("miso moved without a pin edge");
  chk_int_release: assert property ($rose(int_n) |-> since_cs < 4'd12)
    else $error("int_n released without a host write");
endmodule : ceie_top_props
bind ceie_top ceie_top_props #(.N_INPUTS(N_INPUTS), .GROUP_SIZE(GROUP_SIZE)) ceie_top_props_i (
  .clock(clock), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
  .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .sample_valid(sample_valid),
  .cmp_irq_pending(cmp_irq_pending), .int_n(int_n));
`default_nettype wire

// [verification/ceie_host_model.sv]
// serial host that frames register accesses toward the block
`timescale 1ns/1ps
`default_nettype none
module ceie_host_model (
  input  wire logic clock,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  // 32-bit frame, 8-clock half periods; read data taken just before sclk falls 8 to 31
  task automatic xfer(input logic w, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q);
    logic [31:0] f;
    f = {w, a, d, 1'b0};
    q = '0;
    @(posedge clock);
    spi_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_mosi <= f[i];
      repeat (8) @(posedge clock);
      spi_sclk <= 1'b1;
      repeat (8) @(posedge clock);
      if (i >= 1 && i <= 24)
        q = {q[22:0], spi_miso};
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge clock);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line shows no stale bit
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : ceie_host_model
`default_nettype wire

// [verification/ceie_top_tb.sv]
// register and edge tests for the comparator edge interrupt select block
`timescale 1ns/1ps
`default_nettype none
module ceie_top_tb;
  import ceie_pkg::*;
  logic                clock, rst_n, cs_n, sclk, mosi, miso, miso_oe_n, sample_valid, int_n;
  ceie_levels_t [23:0] cmp_levels;
  logic [5:0][1:0]     thr, tv;
  logic [23:0]         pend, rd, fld;
  logic [5:0]          sel;
  logic [1:0]          code, t;
  int                  errors, total_checks, n;
  int                  chans [6] = '{0, 4, 6, 12, 19, 23};
  // 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ceie_top ceie_top_i (
    .clock(clock), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .sample_valid(sample_valid),
    .cmp_levels(cmp_levels), .group0_threshold_level(thr[0]),
    .group1_threshold_level(thr[1]), .group2_threshold_level(thr[2]),
    .group3_threshold_level(thr[3]), .group4_threshold_level(thr[4]),
    .group5_threshold_level(thr[5]), .cmp_irq_pending(pend), .int_n(int_n));
  ceie_host_model ceie_host_model_i (
    .clock(clock), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso));
  // compare one result and count it
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    ceie_host_model_i.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdchk(input logic [5:0] a, input logic [23:0] exp);
    ceie_host_model_i.xfer(1'b0, a, 24'h0, rd);
    chk(rd, exp);
  endtask : rdchk
  // one sample; input k sits just above level lv when hi
  task automatic smp(input int k, input logic hi, input logic [1:0] lv);
    ceie_levels_t [23:0] v;
    v = '0;
    if (hi)
      v[k] = ceie_levels_t'((5'h2 << lv) - 5'h1);
    @(posedge clock);
    cmp_levels <= v;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : smp
  task automatic results();
    $display("errors %0d, checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // watchdog against a hang
  initial
  begin
    repeat (90000) @(posedge clock);
    errors++;
    results();
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    cmp_levels = '0;
    thr = '1;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk(pend, 24'h0);
    chk({23'h0, int_n}, 24'h1);
    rdchk(6'h22, 24'h0);
    rdchk(6'h23, 24'h0);
    wr(6'h22, 24'hA5C3E1);
    wr(6'h23, 24'h5A3C1E);
    wr(6'h30, 24'hFFFFFF);
    rdchk(6'h22, 24'hA5C3E1);
    rdchk(6'h23, 24'h5A3C1E);
    rdchk(6'h30, 24'h0);
    wr(6'h22, 24'h0);
    wr(6'h23, 24'h0);
    smp(0, 1'b0, 2'h0);
    foreach (chans[i])
      for (int c = 0; c < 4; c++)
      begin
        n = chans[i];
        code = 2'(c);
        t = 2'((n + c) % 3);
        tv = '1;
        tv[n / 4] = t;
        thr <= tv; // other groups sit at the top level
        sel = n < 12 ? 6'h22 : 6'h23;
        fld = 24'(c) << (2 * (n % 12));
        wr(sel, fld);
        rdchk(sel, fld);
        smp(n, 1'b1, t);
        smp(n, 1'b1, t);
        chk(pend, code[0] ? 24'h1 << n : 24'h0);
        chk({23'h0, int_n}, {23'h0, !code[0]});
        rdchk(6'h3B, 24'h1 << n);
        wr(6'h3A, 24'hFFFFFF);
        smp(n, 1'b0, t);
        chk(pend, code[1] ? 24'h1 << n : 24'h0);
        if (c == 1)
          rdchk(6'h3C, 24'h1 << n);
        wr(6'h3A, 24'hFFFFFF);
        chk(pend, 24'h0);
      end
    results();
  end
endmodule : ceie_top_tb
`default_nettype wire
